// ==== core/mcs_pkg.sv ====
package mcs_pkg;
  // Register byte offsets on the APB bus.
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_REC_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REC_CFG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_REC_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_END_POS = 8'h14;

  // Control and status field positions.
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STOP = 1;
  localparam int unsigned CTRL_IDX_LO = 8;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_IDX_LO = 8;
  localparam int unsigned STAT_STATE_LO = 16;

  // Path record configuration word layout.
  localparam int unsigned CFG_IS_POS = 0;
  localparam int unsigned CFG_MODE_LO = 1;
  localparam int unsigned CFG_INS = 3;
  localparam int unsigned CFG_EXT = 4;
  localparam int unsigned CFG_OVL = 5;
  localparam int unsigned CFG_AUTO = 6;
  localparam int unsigned CFG_DLY_LO = 8;
  localparam int unsigned DLY_W = 8;

  // Reset values.
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Table depth and delay time base.
  localparam int unsigned NREC_DEF = 8;
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned DLY_UNIT_US = 1000;
  localparam int unsigned DLY_TICK_CYC = DLY_UNIT_US * CLK_FREQ_MHZ;

  // End position modes.
  typedef enum logic [1:0] {
    MODE_ABS = 2'h0,
    MODE_REL = 2'h1,
    MODE_INC = 2'h2,
    MODE_CAP = 2'h3
  } mcs_mode_t;

  // Sequencer states, Gray coded along idle, load, issue, run, delay.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_ISSUE = 3'h3,
    ST_RUN = 3'h2,
    ST_DELAY = 3'h6
  } mcs_state_t;
endpackage

// ==== core/mcs_pos_if.sv ====
`timescale 1ns/1ps
interface mcs_pos_if;
  import mcs_pkg::*;
  logic calc_en;
  mcs_mode_t mode;
  logic [31:0] cmd;
  logic [31:0] fb;
  logic [31:0] cap;
  logic [31:0] end_pos;
  modport seq (output calc_en, output mode, output cmd, output fb, output cap, input end_pos);
  modport calc (input calc_en, input mode, input cmd, input fb, input cap, output end_pos);
endinterface

// ==== core/mcs_endpos.sv ====
`timescale 1ns/1ps
module mcs_endpos (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Calculation request and result.
  mcs_pos_if.calc pos
);
  import mcs_pkg::*;

  logic [31:0] end_pos_ff;
  logic [31:0] nxt_end_pos_ff;

  // The stored result doubles as the previous end position for incremental moves.
  always_comb begin
    nxt_end_pos_ff = end_pos_ff;
    if (pos.calc_en) begin
      case (pos.mode)
        MODE_ABS: nxt_end_pos_ff = pos.cmd;
        MODE_REL: nxt_end_pos_ff = pos.fb + pos.cmd;
        MODE_INC: nxt_end_pos_ff = end_pos_ff + pos.cmd;
        MODE_CAP: nxt_end_pos_ff = pos.cap + pos.cmd;
        default: nxt_end_pos_ff = pos.cmd;
      endcase
    end
  end

  // Result register.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      end_pos_ff <= 32'h0000_0000;
    end else begin
      end_pos_ff <= nxt_end_pos_ff;
    end
  end

  assign pos.end_pos = end_pos_ff;
endmodule

// ==== core/mcs_sequencer.sv ====
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mcs_sequencer #(
  parameter int unsigned NREC = mcs_pkg::NREC_DEF,
  parameter int unsigned DLY_TICK_CYC = mcs_pkg::DLY_TICK_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mcs_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Motion profile generator.
  output logic cmd_valid_o,
  output logic cmd_pos_o,
  output logic cmd_replace_o,
  output logic cmd_merge_o,
  output logic [31:0] cmd_value_o,
  input wire logic motion_done_i,
  input wire logic decel_i,
  input wire logic [31:0] feedback_position_i,
  input wire logic [31:0] capture_data_i
);
  import mcs_pkg::*;

  localparam int unsigned IW = (NREC > 1) ? $clog2(NREC) : 1;
  localparam int unsigned TW = $clog2(DLY_TICK_CYC + 1);
  localparam logic [IW-1:0] LAST_IDX = IW'(NREC - 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(DLY_TICK_CYC - 1);
  localparam logic [DLY_W-1:0] DLY_MAX = {DLY_W{1'b1}};

  // Bus decode.
  logic acc;
  logic wr_en;
  logic mapped;
  logic start_wr;
  logic stop_wr;
  logic [IW-1:0] start_idx;

  // Path record table.
  logic [31:0] cfg_ff [NREC];
  logic [31:0] data_ff [NREC];
  logic [IW-1:0] rec_idx_ff;
  logic [IW-1:0] nxt_rec_idx_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata_ff;

  // Sequencer state.
  mcs_state_t state_ff;
  mcs_state_t nxt_state_ff;
  logic [IW-1:0] cur_idx_ff;
  logic [IW-1:0] nxt_cur_idx_ff;
  logic [31:0] cur_cfg_ff;
  logic [31:0] nxt_cur_cfg_ff;
  logic [31:0] cur_data_ff;
  logic [31:0] nxt_cur_data_ff;
  logic cmd_valid_ff;
  logic nxt_cmd_valid_ff;
  logic cmd_pos_ff;
  logic nxt_cmd_pos_ff;
  logic cmd_replace_ff;
  logic nxt_cmd_replace_ff;
  logic cmd_merge_ff;
  logic nxt_cmd_merge_ff;
  logic [31:0] cmd_value_ff;
  logic [31:0] nxt_cmd_value_ff;

  // Delay timing.
  logic [TW-1:0] tick_cnt_ff;
  logic [TW-1:0] nxt_tick_cnt_ff;
  logic [DLY_W-1:0] dly_cnt_ff;
  logic [DLY_W-1:0] nxt_dly_cnt_ff;
  logic tick;
  logic dly_clr;
  logic dly_done;

  // Look-ahead at the record that follows the running one.
  logic [IW-1:0] next_idx;
  logic [31:0] next_cfg;
  logic next_ins;
  logic next_ext;
  logic ovl_eff;

  mcs_pos_if pos_if ();

  // APB decode; the slave never inserts wait states.
  assign acc = psel_i & penable_i;
  assign wr_en = acc & pwrite_i;
  assign pready_o = acc;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o = prdata_ff;
  assign start_wr = wr_en && (paddr_i == OFF_CTRL) && pwdata_i[CTRL_START];
  assign stop_wr = wr_en && (paddr_i == OFF_CTRL) && pwdata_i[CTRL_STOP];
  assign start_idx = pwdata_i[CTRL_IDX_LO +: IW];

  always_comb begin
    case (paddr_i)
      OFF_CTRL, OFF_STATUS, OFF_REC_IDX, OFF_REC_CFG, OFF_REC_DATA, OFF_END_POS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase so the answer comes from a flip-flop.
  always_comb begin
    nxt_prdata_ff = prdata_ff;
    if (psel_i && !penable_i && !pwrite_i) begin
      nxt_prdata_ff = 32'h0000_0000;
      case (paddr_i)
        OFF_STATUS: begin
          nxt_prdata_ff[STAT_BUSY] = (state_ff != ST_IDLE);
          nxt_prdata_ff[STAT_IDX_LO +: IW] = cur_idx_ff;
          nxt_prdata_ff[STAT_STATE_LO +: 3] = state_ff;
        end
        OFF_REC_IDX: nxt_prdata_ff[IW-1:0] = rec_idx_ff;
        OFF_REC_CFG: nxt_prdata_ff = cfg_ff[rec_idx_ff];
        OFF_REC_DATA: nxt_prdata_ff = data_ff[rec_idx_ff];
        OFF_END_POS: nxt_prdata_ff = pos_if.end_pos;
        default: nxt_prdata_ff = 32'h0000_0000;
      endcase
    end
  end

  // Record pointer for table access.
  always_comb begin
    nxt_rec_idx_ff = rec_idx_ff;
    if (wr_en && paddr_i == OFF_REC_IDX) begin
      nxt_rec_idx_ff = pwdata_i[IW-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_ff <= 32'h0000_0000;
      rec_idx_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata_ff;
      rec_idx_ff <= nxt_rec_idx_ff;
    end
  end

  // One table entry per generate step; software may rewrite entries while running.
  for (genvar g = 0; g < NREC; g++) begin : g_rec
    logic [31:0] nxt_cfg;
    logic [31:0] nxt_data;
    always_comb begin
      nxt_cfg = cfg_ff[g];
      nxt_data = data_ff[g];
      if (wr_en && rec_idx_ff == IW'(g)) begin
        if (paddr_i == OFF_REC_CFG) begin
          nxt_cfg = pwdata_i;
        end
        if (paddr_i == OFF_REC_DATA) begin
          nxt_data = pwdata_i;
        end
      end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cfg_ff[g] <= CFG_RST;
        data_ff[g] <= DATA_RST;
      end else begin
        cfg_ff[g] <= nxt_cfg;
        data_ff[g] <= nxt_data;
      end
    end
  end

  // Look-ahead decode; insertion masks overlap, and a speed follower cancels it.
  assign next_idx = (cur_idx_ff == LAST_IDX) ? '0 : cur_idx_ff + 1'b1;
  assign next_cfg = cfg_ff[next_idx];
  assign next_ins = next_cfg[CFG_INS];
  assign next_ext = next_cfg[CFG_EXT];
  assign ovl_eff = cur_cfg_ff[CFG_OVL] & ~next_ins & next_cfg[CFG_IS_POS];

  // Delay time base, restarted with each delay so that units are whole.
  assign tick = (tick_cnt_ff == TICK_LAST);
  assign dly_done = (dly_cnt_ff >= cur_cfg_ff[CFG_DLY_LO +: DLY_W]);

  always_comb begin
    nxt_tick_cnt_ff = tick ? '0 : tick_cnt_ff + 1'b1;
    nxt_dly_cnt_ff = dly_cnt_ff;
    if (tick && dly_cnt_ff != DLY_MAX) begin
      nxt_dly_cnt_ff = dly_cnt_ff + 1'b1;
    end
    if (dly_clr) begin
      nxt_tick_cnt_ff = '0;
      nxt_dly_cnt_ff = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_ff <= '0;
      dly_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt_ff;
      dly_cnt_ff <= nxt_dly_cnt_ff;
    end
  end

  // End position request uses the record being loaded.
  assign pos_if.calc_en = (state_ff == ST_LOAD) && cfg_ff[cur_idx_ff][CFG_IS_POS];
  assign pos_if.mode = mcs_mode_t'(cfg_ff[cur_idx_ff][CFG_MODE_LO +: 2]);
  assign pos_if.cmd = data_ff[cur_idx_ff];
  assign pos_if.fb = feedback_position_i;
  assign pos_if.cap = capture_data_i;

  mcs_endpos u_endpos (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pos(pos_if.calc)
  );

  // Sequencer next state. Speed and position commands take the same path.
  always_comb begin
    nxt_state_ff = state_ff;
    nxt_cur_idx_ff = cur_idx_ff;
    nxt_cur_cfg_ff = cur_cfg_ff;
    nxt_cur_data_ff = cur_data_ff;
    nxt_cmd_valid_ff = 1'b0;
    nxt_cmd_pos_ff = cmd_pos_ff;
    nxt_cmd_replace_ff = cmd_replace_ff;
    nxt_cmd_merge_ff = cmd_merge_ff;
    nxt_cmd_value_ff = cmd_value_ff;
    dly_clr = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_wr) begin
          nxt_cur_idx_ff = start_idx;
          nxt_state_ff = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Fields are frozen here so table rewrites cannot disturb a running command.
        nxt_cur_cfg_ff = cfg_ff[cur_idx_ff];
        nxt_cur_data_ff = data_ff[cur_idx_ff];
        nxt_state_ff = ST_ISSUE;
      end
      ST_ISSUE: begin
        nxt_cmd_valid_ff = 1'b1;
        nxt_cmd_pos_ff = cur_cfg_ff[CFG_IS_POS];
        nxt_cmd_replace_ff = cur_cfg_ff[CFG_INS] & cur_cfg_ff[CFG_EXT];
        nxt_cmd_merge_ff = cur_cfg_ff[CFG_INS] & ~cur_cfg_ff[CFG_EXT];
        nxt_cmd_value_ff = cur_cfg_ff[CFG_IS_POS] ? pos_if.end_pos : cur_data_ff;
        dly_clr = 1'b1;
        nxt_state_ff = ST_RUN;
      end
      ST_RUN: begin
        if (!cur_cfg_ff[CFG_AUTO]) begin
          if (motion_done_i) begin
            nxt_state_ff = ST_IDLE;
          end
        end else if (next_ins && next_ext) begin
          // The running command is cut short with no regard to its delay.
          nxt_cur_idx_ff = next_idx;
          nxt_state_ff = ST_LOAD;
        end else if (next_ins) begin
          if (dly_done) begin
            nxt_cur_idx_ff = next_idx;
            nxt_state_ff = ST_LOAD;
          end
        end else if (ovl_eff) begin
          if (dly_done || decel_i) begin
            nxt_cur_idx_ff = next_idx;
            nxt_state_ff = ST_LOAD;
          end
        end else if (motion_done_i) begin
          dly_clr = 1'b1;
          nxt_state_ff = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          nxt_cur_idx_ff = next_idx;
          nxt_state_ff = ST_LOAD;
        end
      end
      default: nxt_state_ff = ST_IDLE;
    endcase
    if (stop_wr) begin
      nxt_state_ff = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cur_idx_ff <= '0;
      cur_cfg_ff <= CFG_RST;
      cur_data_ff <= DATA_RST;
      cmd_valid_ff <= 1'b0;
      cmd_pos_ff <= 1'b0;
      cmd_replace_ff <= 1'b0;
      cmd_merge_ff <= 1'b0;
      cmd_value_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state_ff;
      cur_idx_ff <= nxt_cur_idx_ff;
      cur_cfg_ff <= nxt_cur_cfg_ff;
      cur_data_ff <= nxt_cur_data_ff;
      cmd_valid_ff <= nxt_cmd_valid_ff;
      cmd_pos_ff <= nxt_cmd_pos_ff;
      cmd_replace_ff <= nxt_cmd_replace_ff;
      cmd_merge_ff <= nxt_cmd_merge_ff;
      cmd_value_ff <= nxt_cmd_value_ff;
    end
  end

  // Command outputs to the profile generator.
  assign cmd_valid_o = cmd_valid_ff;
  assign cmd_pos_o = cmd_pos_ff;
  assign cmd_replace_o = cmd_replace_ff;
  assign cmd_merge_o = cmd_merge_ff;
  assign cmd_value_o = cmd_value_ff;
endmodule

// ==== tb/mcs_seq_monitor.sv ====
`timescale 1ns/1ps
module mcs_seq_monitor #(
  parameter int unsigned NREC = mcs_pkg::NREC_DEF,
  parameter int unsigned DLY_TICK_CYC = mcs_pkg::DLY_TICK_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mcs_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Motion profile generator.
  input wire logic cmd_valid_o,
  input wire logic cmd_pos_o,
  input wire logic cmd_replace_o,
  input wire logic cmd_merge_o,
  input wire logic [31:0] cmd_value_o,
  input wire logic motion_done_i,
  input wire logic decel_i,
  input wire logic [31:0] feedback_position_i,
  input wire logic [31:0] capture_data_i
);
  import mcs_pkg::*;
  logic mapped, ctrl_wr, done_seen_ff, nxt_done_seen;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Decode of the bus as a write to the control word.
  assign ctrl_wr = psel_i && penable_i && pwrite_i && (paddr_i == OFF_CTRL);
  assign mapped = paddr_i inside {OFF_CTRL, OFF_STATUS, OFF_REC_IDX, OFF_REC_CFG,
    OFF_REC_DATA, OFF_END_POS};
  sequence start_wr;
    ctrl_wr && pwdata_i[CTRL_START];
  endsequence
  sequence stop_wr;
    ctrl_wr && pwdata_i[CTRL_STOP];
  endsequence
  // A completion or a start arms a plain dispatch; each dispatch uses it up.
  always_comb begin
    nxt_done_seen = done_seen_ff;
    if (motion_done_i || (ctrl_wr && pwdata_i[CTRL_START])) nxt_done_seen = 1'b1;
    if (cmd_valid_o) nxt_done_seen = 1'b0;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) done_seen_ff <= 1'b0;
    else done_seen_ff <= nxt_done_seen;
  end
  pready_zero_wait_a: assert property (pready_o == (psel_i && penable_i))
    else $error("pready does not follow the access phase");
  unmapped_err_a: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
    else $error("pslverr wrong for the address");
  valid_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o [*2])
    else $error("dispatch pulse too long or too close");
  start_latency_a: assert property (start_wr |-> ##3 cmd_valid_o)
    else $error("no dispatch three cycles after start");
  plain_waits_done_a: assert property (cmd_valid_o && !cmd_pos_o && !cmd_replace_o
    && !cmd_merge_o |-> done_seen_ff)
    else $error("speed command dispatched before completion");
  output_hold_a: assert property (!cmd_valid_o |-> $stable(cmd_value_o) && $stable(cmd_pos_o)
    && $stable(cmd_replace_o) && $stable(cmd_merge_o))
    else $error("command outputs changed without dispatch");
  insert_kind_a: assert property (!(cmd_replace_o && cmd_merge_o))
    else $error("replace and merge both set");
  stop_quiet_a: assert property (stop_wr |-> ##2 !cmd_valid_o [*3])
    else $error("dispatch after stop");
endmodule
bind mcs_sequencer mcs_seq_monitor #(.NREC(NREC), .DLY_TICK_CYC(DLY_TICK_CYC)) u_mon (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .cmd_valid_o(cmd_valid_o),
  .cmd_pos_o(cmd_pos_o),
  .cmd_replace_o(cmd_replace_o),
  .cmd_merge_o(cmd_merge_o),
  .cmd_value_o(cmd_value_o),
  .motion_done_i(motion_done_i),
  .decel_i(decel_i),
  .feedback_position_i(feedback_position_i),
  .capture_data_i(capture_data_i)
);

// ==== tb/mcs_mpg_model.sv ====
`timescale 1ns/1ps
module mcs_mpg_model (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Dispatch in, run length of each move in cycles.
  input wire logic cmd_valid_i,
  input wire logic [15:0] run_len_i,
  // Completion pulse and deceleration level.
  output logic motion_done_o,
  output logic decel_o
);
  logic [15:0] left_ff, nxt_left;
  // Any dispatch restarts the move, since a replaced or merged move runs on.
  always_comb begin
    nxt_left = left_ff;
    if (cmd_valid_i) nxt_left = run_len_i;
    else if (left_ff != 16'h0) nxt_left = left_ff - 16'h1;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) left_ff <= 16'h0;
    else left_ff <= nxt_left;
  end
  // The last quarter of a move decelerates; completion is a one-cycle pulse.
  assign decel_o = (left_ff != 16'h0) && (left_ff < (run_len_i >> 2));
  assign motion_done_o = (left_ff == 16'h1);
endmodule

// ==== tb/motion_command_sequencer_tb.sv ====
`timescale 1ns/1ps
module motion_command_sequencer_tb;
  import mcs_pkg::*;
  localparam int TICK = 4;
  logic core_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [15:0] run_len = 16'h0010;
  logic [31:0] pwdata_i = 32'h0, feedback_position_i = 32'h0, capture_data_i = 32'h0;
  logic [31:0] prdata_o, cmd_value_o, rd, seed = 32'h0000_0061;
  logic pready_o, pslverr_o, cmd_valid_o, cmd_pos_o, cmd_replace_o, cmd_merge_o;
  logic motion_done_i, decel_i, er;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  int vc[$], dc[$];
  logic [31:0] vv[$];
  logic [2:0] vk[$];
  // 200 MHz clock.
  always #2.5 core_clk_i = ~core_clk_i;
  mcs_sequencer #(.NREC(8), .DLY_TICK_CYC(TICK)) dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .cmd_valid_o(cmd_valid_o),
    .cmd_pos_o(cmd_pos_o),
    .cmd_replace_o(cmd_replace_o),
    .cmd_merge_o(cmd_merge_o),
    .cmd_value_o(cmd_value_o),
    .motion_done_i(motion_done_i),
    .decel_i(decel_i),
    .feedback_position_i(feedback_position_i),
    .capture_data_i(capture_data_i)
  );
  mcs_mpg_model u_mpg (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_o),
    .run_len_i(run_len), .motion_done_o(motion_done_i), .decel_o(decel_i));
  // Log dispatches and completions at the falling edge, where outputs are settled.
  always @(negedge core_clk_i) begin
    cyc++;
    if (motion_done_i === 1'b1) dc.push_back(cyc);
    if (cmd_valid_o === 1'b1) begin
      vc.push_back(cyc);
      vv.push_back(cmd_value_o);
      vk.push_back({cmd_pos_o, cmd_replace_o, cmd_merge_o});
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Flags are {auto, overlap, external, insert}.
  function automatic logic [31:0] cfg(input logic p, input logic [1:0] m, input logic [3:0] f,
    input logic [7:0] dl);
    return {16'h0, dl, 1'b0, f, m, p};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high, then one idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 64);
    rd = prdata_o;
    er = pslverr_o;
    if (n >= 64) error_cnt++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wrec(input logic [7:0] i, input logic [31:0] c, input logic [31:0] d);
    apb(1'b1, OFF_REC_IDX, {24'h0, i});
    apb(1'b1, OFF_REC_CFG, c);
    apb(1'b1, OFF_REC_DATA, d);
  endtask
  // Start at record 0, wait for n dispatches and the last move, then stop.
  task automatic run(input int n);
    int t;
    t = 0;
    vc.delete();
    dc.delete();
    vv.delete();
    vk.delete();
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    while (vc.size() < n && t < 4000) begin
      @(posedge core_clk_i);
      t++;
    end
    if (t >= 4000) error_cnt++;
    repeat (int'(run_len) + 8) @(posedge core_clk_i);
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    repeat (4) @(posedge core_clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run time.
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    int g[4];
    logic [31:0] d[5];
    logic [31:0] e;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    apb(1'b0, OFF_REC_CFG, 32'h0);
    chk("cfg reset", CFG_RST, rd);
    apb(1'b0, OFF_REC_DATA, 32'h0);
    chk("data reset", DATA_RST, rd);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    $display("test registers done");
    // Every end position mode, then a speed record, chained by auto-advance.
    feedback_position_i <= rnd();
    capture_data_i <= rnd();
    for (int i = 0; i < 5; i++) begin
      d[i] = rnd();
      wrec(i[7:0], cfg(i < 4, i[1:0], (i < 4) ? 4'h8 : 4'h0, 8'h00), d[i]);
    end
    // Record 4 is still selected, so its random data word must read back.
    apb(1'b0, OFF_REC_DATA, 32'h0);
    chk("data readback", d[4], rd);
    run(5);
    e = feedback_position_i + d[1];
    chk("abs end", d[0], vv[0]);
    chk("rel end", e, vv[1]);
    chk("inc end", e + d[2], vv[2]);
    chk("cap end", capture_data_i + d[3], vv[3]);
    chk("speed value", d[4], vv[4]);
    chk("kinds", 32'h1E, {vk[0][2], vk[1][2], vk[2][2], vk[3][2], vk[4][2]});
    chk("auto count", 32'h5, vc.size());
    // The speed record leaves the last computed end position in place.
    apb(1'b0, OFF_END_POS, 32'h0);
    chk("end pos reg", capture_data_i + d[3], rd);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status idle", 32'h4 << STAT_IDX_LO, rd);
    $display("test end position done");
    // Sequential delay counts from completion, after a speed or a position move.
    for (int i = 0; i < 4; i++) begin
      wrec(8'h00, cfg(i[0], 2'h0, 4'h8, i[1] ? 8'h02 : 8'h00), rnd());
      wrec(8'h01, cfg(1'b1, 2'h0, 4'h0, 8'h00), rnd());
      run(2);
      g[i] = vc[1] - dc[0];
      chk("after done", 32'h1, vc[1] > dc[0]);
    end
    chk("pos delay", 2 * TICK, g[3] - g[1]);
    chk("speed delay", 2 * TICK, g[2] - g[0]);
    $display("test sequential done");
    // External insertion ignores delay and overlap; internal waits the delay.
    run_len <= 16'h0080;
    for (int i = 0; i < 2; i++) begin
      wrec(8'h00, cfg(1'b0, 2'h0, i ? 4'hC : 4'h8, 8'h05), rnd());
      wrec(8'h01, cfg(1'b1, 2'h0, i ? 4'h1 : 4'h7, 8'h00), rnd());
      run(2);
      chk("insert kind", i ? 3'h5 : 3'h6, vk[1]);
      chk("before done", 32'h0, dc.size() > 0 && dc[0] < vc[1]);
      g[i] = vc[1] - vc[0];
    end
    chk("ext no delay", 32'h1, g[0] < 5 * TICK);
    chk("int delay", 32'h1, g[1] >= 5 * TICK && g[1] < 5 * TICK + 8);
    $display("test insertion done");
    // Overlap starts a position move early, never a speed move.
    for (int i = 0; i < 2; i++) begin
      wrec(8'h00, cfg(1'b1, 2'h0, 4'hC, 8'h00), rnd());
      wrec(8'h01, cfg(i == 0, 2'h0, 4'h0, 8'h00), rnd());
      run(2);
      chk("overlap", i ? 32'h0 : 32'h1, dc.size() == 0 || dc[0] > vc[1]);
    end
    // A long overlap delay, legal though discouraged, falls back on deceleration.
    wrec(8'h00, cfg(1'b1, 2'h0, 4'hC, 8'hFF), rnd());
    wrec(8'h01, cfg(1'b1, 2'h0, 4'h0, 8'h00), rnd());
    run(2);
    g[0] = vc[1] - vc[0];
    chk("decel start", 32'h1, g[0] > 3 * int'(run_len) / 4 && g[0] < int'(run_len));
    $display("test overlap done");
    give_verdict();
  end
endmodule
